// ==== hdl/pss_top.sv ====
// Overview of operation
// RULE_01 - bypass PLL when division alone suffices
// RULE_02 - requester pre-selects PLL input, divider one
// RULE_03 - apply found settings, switch to PLL
// RULE_04 - return achieved system frequency in kHz
// RULE_05 - mode codes: exact, at-most, at-least, closest
// RULE_06 - result codes zero through four
// RULE_07 - PLL output never above maximum
// RULE_08 - reject input frequency out of range
// RULE_09 - reject target frequency out of range
// RULE_10 - bad frequency: no change, echo input
// RULE_11 - exact match always preferred first
// RULE_12 - exact mode succeeds only on equality
// RULE_13 - at-most mode never exceeds target
// RULE_14 - at-least mode never below target
// RULE_15 - closest mode minimises distance to target
// RULE_16 - bad mode: code, no change, echo
// RULE_17 - no solution: code, no change, echo
// RULE_18 - divider over maximum means bad frequency
// RULE_19 - zero poll limit waits forever
// RULE_20 - poll limit exhausted: lock failure, restore
// RULE_21 - PLL locks within bounded microseconds
// RULE_22 - requester sizes poll limit from frequency
// RULE_23 - start strobe with stable args, done pulse
`timescale 1ns/100ps
`default_nettype none
module pss_top
  import pss_pkg::*;
#(
  parameter int unsigned M_MAX = 32,
  parameter logic [31:0] CCO_MIN_KHZ = 32'h0002_49f0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire pss_req_s req,
  input wire logic pll_lock,
  output var pss_cfg_s cfg,
  output logic busy,
  output logic done,
  output logic [2:0] out_result_code,
  output logic [31:0] out_system_freq_khz
);
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_check = 3'b001,
    st_search = 3'b010,
    st_divide = 3'b011,
    st_lock = 3'b100,
    st_finish = 3'b101
  } pss_state_e;

  pss_state_e state_q;
  pss_req_s req_q;
  pss_cfg_s cfg_q;
  pss_cfg_s cfg_old_q;
  logic busy_q;
  logic done_q;
  logic [2:0] code_q;
  logic [2:0] res_q;
  logic [31:0] freq_q;
  logic [5:0] m_q;
  logic [7:0] d_q;
  logic found_q;
  logic [5:0] best_m_q;
  logic [7:0] best_d_q;
  logic [23:0] best_err_q;
  logic [31:0] poll_q;
  logic div_start_q;
  logic div_done;
  logic [23:0] div_quot;

  logic [15:0] fin;
  logic [15:0] tgt;
  logic [1:0] mode;
  logic [31:0] limit;
  logic [23:0] fout;
  logic [23:0] prod;
  logic [23:0] err;
  logic [23:0] best_fout;
  logic qualify;
  logic better;
  logic search_end;
  logic bad_freq;
  logic bad_mode;
  logic poll_out;

  assign fin = req_q.arg_input_freq_khz[15:0];
  assign tgt = req_q.arg_target_freq_khz[15:0];
  assign mode = req_q.arg_match_mode[1:0];
  assign limit = req_q.arg_lock_poll_limit;

  // RULE_08 RULE_09 RULE_18 range and divider checks
  assign bad_freq = (req_q.arg_input_freq_khz < FIN_MIN_KHZ)
                 || (req_q.arg_input_freq_khz > FIN_MAX_KHZ)
                 || (req_q.arg_target_freq_khz < TGT_MIN_KHZ)
                 || (req_q.arg_target_freq_khz > TGT_MAX_KHZ)
                 || (24'(fin) > 24'(tgt) * SYS_DIV_MAX);
  // RULE_05 RULE_16 mode encoding check
  assign bad_mode = (req_q.arg_match_mode > MODE_MAX);

  // candidate fin*m/d is scored by |fin*m - tgt*d| / d, compared by cross products
  assign fout = 24'(fin) * 24'(m_q);
  assign prod = 24'(tgt) * 24'(d_q);
  assign err = (fout >= prod) ? (fout - prod) : (prod - fout);
  assign best_fout = 24'(fin) * 24'(best_m_q);
  // RULE_07 PLL output ceiling
  assign search_end = (m_q > 6'(M_MAX)) || (fout > PLL_MAX_KHZ);
  // RULE_11 exact scores zero, wins
  assign better = !found_q
               || ((32'(err) * 32'(best_d_q)) < (32'(best_err_q) * 32'(d_q)));
  // RULE_19 RULE_20 poll exhaustion
  assign poll_out = !pll_lock && (limit != 32'h0) && (poll_q == limit - 32'h1);

  always_comb begin
    unique case (pss_mode_e'(mode))
      // RULE_12 equality only
      match_exact: qualify = (err == 24'h0);
      // RULE_13 never above target
      match_at_most: qualify = (fout <= prod);
      // RULE_14 never below target
      match_at_least: qualify = (fout >= prod);
      // RULE_15 any, ranked by distance
      match_closest: qualify = 1'b1;
    endcase
  end

  // smallest post divider whose oscillator stays above its floor
  function automatic logic [3:0] pick_post_div(input logic [23:0] f);
    logic [3:0] p;
    p = 4'h8;
    for (int i = 3; i >= 0; i--) begin
      if ((32'(f) << (i + 1)) >= CCO_MIN_KHZ) p = 4'(1 << i);
    end
    return p;
  endfunction

  pss_divider #(
    .NW(24),
    .DW(8)
  ) u_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(div_start_q),
    .num(best_fout),
    .den(best_d_q),
    .done(div_done),
    .quot(div_quot)
  );

  // sequencing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= st_idle;
    end else if (clk_en) begin
      unique case (state_q)
        st_idle: if (start) state_q <= st_check;
        st_check: state_q <= (bad_freq || bad_mode) ? st_finish : st_search;
        st_search: if (search_end) state_q <= found_q ? st_divide : st_finish;
        st_divide: if (div_done) state_q <= (best_m_q == 6'h01) ? st_finish : st_lock;
        st_lock: if (pll_lock || poll_out) state_q <= st_finish;
        st_finish: state_q <= st_idle;
        default: state_q <= st_idle;
      endcase
    end
  end

  // RULE_23 arguments caught at the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_q <= '0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == st_idle && start) begin
        req_q <= req;
        busy_q <= 1'b1;
      end else if (state_q == st_finish) begin
        busy_q <= 1'b0;
      end
    end
  end

  // search walks d fastest, m ascending; strict improvement keeps the lowest m
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      m_q <= 6'h01;
      d_q <= 8'h01;
      found_q <= 1'b0;
      best_m_q <= 6'h01;
      best_d_q <= 8'h01;
      best_err_q <= 24'h0;
      div_start_q <= 1'b0;
    end else if (clk_en) begin
      div_start_q <= 1'b0;
      if (state_q == st_check) begin
        m_q <= 6'h01;
        d_q <= 8'h01;
        found_q <= 1'b0;
      end else if (state_q == st_search) begin
        if (search_end) begin
          div_start_q <= found_q;
        end else begin
          if (qualify && better) begin
            found_q <= 1'b1;
            best_m_q <= m_q;
            best_d_q <= d_q;
            best_err_q <= err;
          end
          if (d_q == 8'hff) begin
            d_q <= 8'h01;
            m_q <= m_q + 6'h01;
          end else begin
            d_q <= d_q + 8'h01;
          end
        end
      end
    end
  end

  // clock settings; bypass sets system divider and select at once, the PLL path changes them only once lock is seen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RESET;
      cfg_old_q <= CFG_RESET;
    end else if (clk_en) begin
      if (state_q == st_check) begin
        cfg_old_q <= cfg_q;
      end else if (state_q == st_divide && div_done) begin
        if (best_m_q == 6'h01) begin
          // RULE_01 division only, bypass
          cfg_q.system_clock_divider <= best_d_q;
          cfg_q.main_sel_pll <= 1'b0;
        end else begin
          // RULE_03 program multiplier, post divider
          cfg_q.pll_fb_mult <= best_m_q;
          cfg_q.pll_post_div <= pick_post_div(best_fout);
        end
      end else if (state_q == st_lock) begin
        if (pll_lock) begin
          // RULE_03 switch main clock
          cfg_q.system_clock_divider <= best_d_q;
          cfg_q.main_sel_pll <= 1'b1;
        end else if (poll_out) begin
          // RULE_20 restore old settings
          cfg_q <= cfg_old_q;
        end
      end
    end
  end

  // RULE_21 lock normally well under LOCK_WAIT_CYC; each cycle is one check
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      poll_q <= 32'h0;
    end else if (clk_en) begin
      if (state_q == st_check) poll_q <= 32'h0;
      else if (state_q == st_lock && !pll_lock) poll_q <= poll_q + 32'h1;
    end
  end

  // RULE_06 pending result code
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      res_q <= result_success;
    end else if (clk_en) begin
      if (state_q == st_check) begin
        if (bad_freq) res_q <= result_bad_frequency;
        else if (bad_mode) res_q <= result_bad_mode;
        else res_q <= result_success;
      end else if (state_q == st_search && search_end && !found_q) begin
        // RULE_17 nothing qualifies
        res_q <= result_no_solution;
      end else if (state_q == st_lock && poll_out) begin
        res_q <= result_lock_failed;
      end
    end
  end

  // RULE_04 RULE_10 result words and done pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      code_q <= result_success;
      freq_q <= 32'h0;
    end else if (clk_en) begin
      done_q <= (state_q == st_finish);
      if (state_q == st_finish) begin
        code_q <= res_q;
        freq_q <= (res_q == result_success) ? {8'h0, div_quot}
                                            : req_q.arg_input_freq_khz;
      end
    end
  end

  assign cfg = cfg_q;
  assign busy = busy_q;
  assign done = done_q;
  assign out_result_code = code_q;
  assign out_system_freq_khz = freq_q;

  // RULE_10 echo input on failure
  property p_fail_echo;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q != result_success |-> freq_q == req_q.arg_input_freq_khz;
  endproperty
  a_fail_echo: assert property (p_fail_echo) else $error("failure did not echo input"); // RULE_10

  // RULE_16 settings kept on failure
  property p_fail_keep;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q != result_success |-> cfg_q == cfg_old_q;
  endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("settings changed on failure"); // RULE_16

  // RULE_18 divider limit rejected
  property p_div_limit;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    state_q == st_check && 24'(fin) > 24'(tgt) * SYS_DIV_MAX
      |-> ##2 (done_q && code_q == result_bad_frequency);
  endproperty
  a_div_limit: assert property (p_div_limit) else $error("divider limit not rejected"); // RULE_18

  // RULE_05 illegal mode code
  property p_bad_mode;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    state_q == st_check && !bad_freq && req_q.arg_match_mode > MODE_MAX
      |-> ##2 (done_q && code_q == result_bad_mode);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("illegal mode not reported"); // RULE_05

  // RULE_12 exact equals target
  property p_exact;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q == result_success && mode == match_exact |-> freq_q == {16'h0, tgt};
  endproperty
  a_exact: assert property (p_exact) else $error("exact mode result differs"); // RULE_12

  // RULE_13 at-most bound
  property p_at_most;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q == result_success && mode == match_at_most |-> freq_q <= {16'h0, tgt};
  endproperty
  a_at_most: assert property (p_at_most) else $error("at-most result above target"); // RULE_13

  // RULE_14 at-least bound
  property p_at_least;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q == result_success && mode == match_at_least
      |-> 32'(best_fout) >= 32'(tgt) * 32'(cfg_q.system_clock_divider);
  endproperty
  a_at_least: assert property (p_at_least) else $error("at-least result below target"); // RULE_14

  // RULE_07 PLL output ceiling
  property p_pll_max;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q == result_success && cfg_q.main_sel_pll
      |-> 24'(fin) * 24'(cfg_q.pll_fb_mult) <= PLL_MAX_KHZ;
  endproperty
  a_pll_max: assert property (p_pll_max) else $error("PLL output above maximum"); // RULE_07

  // RULE_01 bypass when multiplier one
  property p_bypass;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q && code_q == result_success |-> cfg_q.main_sel_pll == (best_m_q != 6'h01);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass choice wrong"); // RULE_01

  // RULE_19 endless wait
  property p_wait_forever;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    state_q == st_lock && limit == 32'h0 && !pll_lock |=> state_q == st_lock;
  endproperty
  a_wait_forever: assert property (p_wait_forever) else $error("zero limit gave up"); // RULE_19

  // RULE_20 lock failure reported
  property p_lock_fail;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    state_q == st_lock && poll_out |-> ##2 (done_q && code_q == result_lock_failed);
  endproperty
  a_lock_fail: assert property (p_lock_fail) else $error("lock failure not reported"); // RULE_20

  // RULE_23 single-cycle done
  property p_done_pulse;
    @(posedge mclk) disable iff (sys_rst || !clk_en)
    done_q |=> !done_q;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // RULE_23
endmodule // pss_top
`default_nettype wire

// ==== include/pss_pkg.sv ====
package pss_pkg;

  // clock and lock timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LOCK_TIME_US = 100;
  localparam int unsigned LOCK_WAIT_CYC = (LOCK_TIME_US * (CLK_HZ / 1_000_000));

  // argument ranges in kHz, plus the PLL ceiling, system divider limit and highest mode code
  localparam logic [31:0] FIN_MIN_KHZ = 32'h0000_2710;
  localparam logic [31:0] FIN_MAX_KHZ = 32'h0000_61a8;
  localparam logic [31:0] TGT_MIN_KHZ = 32'h0000_0001;
  localparam logic [31:0] TGT_MAX_KHZ = 32'h0000_c350;
  localparam logic [23:0] PLL_MAX_KHZ = 24'h00_c350;
  localparam logic [23:0] SYS_DIV_MAX = 24'h00_00ff;
  localparam logic [31:0] MODE_MAX = 32'h0000_0003;

  typedef enum logic [1:0] {
    match_exact = 2'b00,
    match_at_most = 2'b01,
    match_at_least = 2'b10,
    match_closest = 2'b11
  } pss_mode_e;

  typedef enum logic [2:0] {
    result_success = 3'b000,
    result_bad_frequency = 3'b001,
    result_bad_mode = 3'b010,
    result_no_solution = 3'b011,
    result_lock_failed = 3'b100
  } pss_result_e;

  typedef struct packed {
    logic [31:0] arg_input_freq_khz;
    logic [31:0] arg_target_freq_khz;
    logic [31:0] arg_match_mode;
    logic [31:0] arg_lock_poll_limit;
  } pss_req_s;

  // pll_divider_control fields plus system_clock_divider and main clock select
  typedef struct packed {
    logic [5:0] pll_fb_mult;
    logic [3:0] pll_post_div;
    logic [7:0] system_clock_divider;
    logic main_sel_pll;
  } pss_cfg_s;

  localparam pss_cfg_s CFG_RESET = '{
    pll_fb_mult: 6'h01,
    pll_post_div: 4'h1,
    system_clock_divider: 8'h01,
    main_sel_pll: 1'b0
  };

endpackage

// ==== hdl/pss_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_divider #(
  parameter int unsigned NW = 24,
  parameter int unsigned DW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic done,
  output logic [NW-1:0] quot
);
  localparam int unsigned CW = $clog2(NW + 1);

  logic [DW:0] rem_q;
  logic [NW-1:0] quot_q;
  logic [CW-1:0] cnt_q;
  logic done_q;
  logic [DW:0] shifted;
  logic take;

  // remainder stays below den, so DW+1 bits hold the shifted value
  assign shifted = {rem_q[DW-1:0], quot_q[NW-1]};
  assign take = (shifted >= {1'b0, den});

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rem_q <= '0;
      quot_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (start) begin
        rem_q <= '0;
        quot_q <= num;
        cnt_q <= CW'(NW);
      end else if (cnt_q != '0) begin
        rem_q <= take ? (shifted - {1'b0, den}) : shifted;
        quot_q <= {quot_q[NW-2:0], take};
        cnt_q <= cnt_q - 1'b1;
        done_q <= (cnt_q == CW'(1));
      end
    end
  end

  assign done = done_q;
  assign quot = quot_q;
endmodule // pss_divider
`default_nettype wire

// ==== verif/pss_pll_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_pll_model
  import pss_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire pss_cfg_s cfg,
  input wire logic [7:0] lock_dly,
  input wire logic never_lock,
  output logic pll_lock
);
  logic [9:0] pll_q;
  logic [7:0] cnt_q;

  // bounded lock time
  // lock count restarts whenever the loop settings move, so a stale lock never leaks
  always_ff @(posedge mclk) begin
    pll_q <= {cfg.pll_fb_mult, cfg.pll_post_div};
    if (sys_rst || pll_q != {cfg.pll_fb_mult, cfg.pll_post_div}) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // a broken loop never reports lock; a stale count is ignored until it sees the new settings
  assign pll_lock = !never_lock && (pll_q == {cfg.pll_fb_mult, cfg.pll_post_div})
                    && (cnt_q >= lock_dly);
endmodule // pss_pll_model
`default_nettype wire

// ==== verif/pss_top_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module pss_top_bench
  import pss_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  pss_req_s req = '0;
  logic [7:0] lock_dly = 8'h05;
  logic never_lock = 1'b0;
  logic pll_lock;
  logic busy;
  logic done;
  pss_cfg_s cfg;
  pss_cfg_s exp_cfg;
  logic [2:0] out_result_code;
  logic [31:0] out_system_freq_khz;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h50434d6a;
  logic [31:0] bf[7] = '{32'h2ee0, 32'h270f, 32'h61a9, 32'h2710, 32'h2710, 32'h2ee0,
                         32'h0001_2ee0};
  logic [31:0] bt[7] = '{32'hea60, 32'h4e20, 32'h4e20, 32'h0, 32'hc351, 32'h28, 32'h4e20};
  logic [31:0] bm[3] = '{32'h4, 32'hffff_ffff, 32'h8000_0003};

  always #20 mclk = ~mclk;

  pss_top DUT (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start), .req(req),
    .pll_lock(pll_lock), .cfg(cfg), .busy(busy), .done(done),
    .out_result_code(out_result_code), .out_system_freq_khz(out_system_freq_khz)
  );

  pss_pll_model PLL (
    .mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .lock_dly(lock_dly),
    .never_lock(never_lock), .pll_lock(pll_lock)
  );

  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // post divider: smallest of 1,2,4,8 that lifts the oscillator to its floor
  function automatic logic [3:0] pdiv(input logic [31:0] fout);
    for (int p = 1; p < 8; p = p * 2) begin
      if (2 * p * fout >= 32'h0002_49f0) return p[3:0];
    end
    return 4'h8;
  endfunction

  task automatic run(input logic [31:0] fin, input logic [31:0] tgt, input logic [31:0] mode,
                     input logic [31:0] lim, input logic [2:0] ec, input logic [31:0] ef,
                     input pss_cfg_s ecfg, input bit jit);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{fin, tgt, mode, lim};
    start <= 1'b1;
    clk_en <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    // arguments are only held at the taking edge
    req <= ~req;
    #1;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      if (jit) clk_en <= ($random(seed) % 4) != 0;
      // a second strobe while busy must be ignored
      start <= (n == 4) && !(ec inside {3'h1, 3'h2});
      #1;
      n++;
      if (n == 1) chk("busy", {31'h0, busy}, 32'h1);
    end
    if (n >= 20000) begin
      err_count++;
      end_of_test();
    end
    if (!jit && ec inside {3'h1, 3'h2}) chk("latency", n, 32'h2);
    chk("code", {29'h0, out_result_code}, {29'h0, ec});
    chk("freq", out_system_freq_khz, ef);
    chk("cfg", {13'h0, cfg}, {13'h0, ecfg});
    chk("busy_end", {31'h0, busy}, 32'h0);
    @(posedge mclk);
    clk_en <= 1'b1;
    #1;
    if (!jit) chk("done_pulse", {31'h0, done}, 32'h0);
  endtask

  initial begin
    logic [31:0] fin;
    logic [31:0] k;
    exp_cfg = CFG_RESET;
    // clock starts on the pll input with divider one
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("reset_cfg", {13'h0, cfg}, {13'h0, CFG_RESET});
    foreach (bf[i]) run(bf[i], bt[i], 32'h1, 0, result_bad_frequency, bf[i], exp_cfg, 0);
    foreach (bm[i]) run(32'h2ee0, 32'h4e20, bm[i], 0, result_bad_mode, 32'h2ee0, exp_cfg, 0);
    // every mode takes an exact bypass first
    for (int m = 0; m < 4; m++) begin
      run(32'h2ee0, 32'h2ee0, m, 0, result_success, 32'h2ee0, exp_cfg, 0);
    end
    run(32'h2ee0, 32'h61a8, match_exact, 0, result_no_solution, 32'h2ee0, exp_cfg, 0);
    // poll limit: 24 MHz pll output / 10000
    exp_cfg = '{6'h02, 4'h4, 8'h01, 1'b1};
    run(32'h2ee0, 32'h61a8, match_at_most, 32'h960, result_success, 32'h5dc0, exp_cfg, 0);
    never_lock <= 1'b1;
    run(32'h2ee0, 32'h61a8, match_at_least, 3, result_lock_failed, 32'h2ee0, exp_cfg, 0);
    never_lock <= 1'b0;
    lock_dly <= 8'hc8;
    exp_cfg = '{6'h03, 4'h4, 8'h01, 1'b1};
    run(32'h2ee0, 32'h61a8, match_at_least, 0, result_success, 32'h8ca0, exp_cfg, 0);
    exp_cfg = '{6'h04, 4'h2, 8'h03, 1'b1};
    run(32'h2ee0, 32'h4074, match_closest, 0, result_success, 32'h3e80, exp_cfg, 0);
    exp_cfg = '{6'h04, 4'h2, 8'h02, 1'b0};
    run(32'h2ee0, 32'h1770, match_exact, 0, result_success, 32'h1770, exp_cfg, 0);
    for (int i = 0; i < 6; i++) begin
      fin = 32'h2710 + ($unsigned($random(seed)) % 32'h3a99);
      k = 1 + ($unsigned($random(seed)) % (32'hc350 / fin));
      lock_dly <= 8'($random(seed));
      if (k > 1) begin
        exp_cfg = '{k[5:0], pdiv(fin * k), 8'h01, 1'b1};
      end else begin
        exp_cfg = '{exp_cfg.pll_fb_mult, exp_cfg.pll_post_div, 8'h01, 1'b0};
      end
      run(fin, fin * k, $unsigned($random(seed)) % 4, 0, result_success, fin * k, exp_cfg, 1);
    end
    fin = 32'h4 + ($unsigned($random(seed)) % 32'hfff0);
    run(32'h2710, 32'h2710, fin, 0, result_bad_mode, 32'h2710, exp_cfg, 1);
    end_of_test();
  end
endmodule // pss_top_bench
`default_nettype wire
